/* File: common/adc_seq_pkg.sv */
package adc_seq_pkg;
	// Control word carried in the first twelve serial bits of a transfer.
	localparam int CTRL_W = 12;
	localparam int BIT_WRITE = 11;
	localparam int BIT_AUTO_CYCLE = 10;
	localparam int ADDR_HI = 9;
	localparam int ADDR_LO = 6;
	localparam int BIT_MASK_SEL = 3;
	localparam int BIT_RANGE = 1;
	localparam int BIT_CODING = 0;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	// A coding bit of this value gives straight binary, the other value two's complement.
	localparam logic CODING_STRAIGHT = 1'b1;
	// Result word: channel tag above twelve result bits.
	localparam int NUM_CH = 16;
	localparam int CHAN_W = 4;
	localparam int DATA_W = 12;
	localparam int WORD_W = 16;
	localparam int FULL_SCALE_CODES = 4096;
	localparam logic [11:0] SIGN_FLIP = 12'h800;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [3:0] CHAN_ZERO = 4'h0;
	localparam logic [3:0] CHAN_TOP = 4'hF;
	// Serial bit counts.
	localparam logic [4:0] CNT_CTRL_LAST = 5'h0B;
	localparam logic [4:0] CNT_CTRL_DONE = 5'h0C;
	localparam logic [4:0] CNT_WORD = 5'h10;
	// Result buffer depth.
	localparam int FIFO_DEPTH = 32;
	// Register port map, byte addresses.
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam int ST_CONV_LO = 0;
	localparam int ST_PTR_LO = 4;
	localparam int ST_MODE_LO = 8;
	localparam int ST_FULL = 10;
	// Sequencer modes.
	typedef enum logic [1:0] {SEQ_OFF, SEQ_ARM, SEQ_MASK, SEQ_CONSEC} seq_mode_e;
endpackage : adc_seq_pkg

/* File: src/adc_channel_sequencer.sv */
// Our own choices: the address map and strobed register access.
`timescale 1ns/1ns
// How it works
// - Sequencer idle converts the addressed channel.
// - Result word is channel tag plus twelve bits.
// - Lowest control bit picks binary or two's complement.
// - Range bit picks one or two reference spans.
// - Code step is reference over 4096.
// - After mask load, lowest enabled channel first.
// - Each transfer advances to next enabled channel.
// - After highest enabled channel, wrap to lowest.
// - Sequence runs without further control writes.
// - Writes with pattern one-zero keep sequence running.
// - Any other pattern stops the running sequence.
// - Pattern one-one cycles consecutive channels from zero.
// - Address field names last consecutive channel.
// - Mask loads on transfer after zero-one write.
// - First mask bit is channel zero.
// - Control takes first twelve bits only if write set.
module adc_channel_sequencer (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic DIN,
	output logic DOUT,
	output logic DOUT_OE,
	output logic [3:0] MUX_SEL,
	output logic RANGE_SEL,
	output logic CONV_START,
	input wire logic SAR_VALID,
	input wire logic [11:0] SAR_DATA,
	output logic SAR_READY,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA
);
	// Previous pin levels used to find edges.
	logic sclk_q_reg;
	logic cs_n_q_reg;
	// Serial receive state.
	logic [4:0] bit_cnt_reg;
	logic [15:0] din_sh_reg;
	logic [11:0] cap_reg;
	logic cap_valid_reg;
	// Control, mask and sequencer state.
	logic [11:0] ctrl_reg;
	logic [15:0] mask_reg;
	adc_seq_pkg::seq_mode_e mode_reg;
	logic [3:0] ptr_reg;
	logic [3:0] conv_chan_reg;
	// Output side registers.
	logic [15:0] out_sh_reg;
	logic dout_reg;
	logic dout_oe_reg;
	logic [3:0] mux_sel_reg;
	logic conv_start_reg;
	logic sar_ready_reg;
	logic [31:0] rdata_reg;
	// Buffer connections.
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [15:0] fifo_out_data;

	// Edges of the serial pins, which arrive synchronous to CLK.
	wire cs_fall = cs_n_q_reg && !CS_N;
	wire cs_rise = !cs_n_q_reg && CS_N;
	wire sclk_fall = sclk_q_reg && !SCLK && !CS_N;

	// Channel enable per input; the first-received mask bit is channel zero.
	logic [15:0] en_vec;
	logic [15:0] en_new;
	// Channel enables of a mask written over the register port.
	logic [15:0] en_bus;
	genvar gc;
	generate
		for (gc = 0; gc < adc_seq_pkg::NUM_CH; gc++) begin : g_chan
			assign en_vec[gc] = mask_reg[adc_seq_pkg::NUM_CH-1-gc];
			assign en_new[gc] = din_sh_reg[adc_seq_pkg::NUM_CH-1-gc];
			assign en_bus[gc] = WDATA[adc_seq_pkg::NUM_CH-1-gc];
		end
	endgenerate

	// Smallest enabled channel above cur, else the lowest enabled channel.
	function automatic logic [3:0] next_on(input logic [15:0] en, input logic [3:0] cur);
		logic [3:0] res;
		int i;
		res = adc_seq_pkg::CHAN_ZERO;
		for (i = 15; i >= 0; i--) begin
			if (en[i]) begin
				res = 4'(i);
			end
		end
		for (i = 15; i >= 0; i--) begin
			if (en[i] && (4'(i) > cur) && (i < adc_seq_pkg::NUM_CH)) begin
				res = 4'(i);
			end
		end
		return res;
	endfunction : next_on

	// Control write decode: serial end of transfer wins over a bus write in the same cycle.
	wire in_arm = (mode_reg == adc_seq_pkg::SEQ_ARM);
	wire serial_ctrl_wr = cs_rise && !in_arm && cap_valid_reg
		&& cap_reg[adc_seq_pkg::BIT_WRITE];
	wire bus_ctrl_wr = WR && (ADDR == adc_seq_pkg::REG_CTRL);
	wire bus_mask_wr = WR && (ADDR == adc_seq_pkg::REG_MASK);
	wire wr_any = serial_ctrl_wr || bus_ctrl_wr;
	wire [11:0] wr_word = serial_ctrl_wr ? cap_reg : WDATA[11:0];
	wire [1:0] wr_pat = {wr_word[adc_seq_pkg::BIT_AUTO_CYCLE], wr_word[adc_seq_pkg::BIT_MASK_SEL]};
	wire mask_take = cs_rise && in_arm && (bit_cnt_reg == adc_seq_pkg::CNT_WORD);
	wire [3:0] last_chan = ctrl_reg[adc_seq_pkg::ADDR_HI:adc_seq_pkg::ADDR_LO];
	wire seq_idle = (mode_reg == adc_seq_pkg::SEQ_OFF) || in_arm;

	// Result coding and tagging.
	wire [11:0] coded = (ctrl_reg[adc_seq_pkg::BIT_CODING] == adc_seq_pkg::CODING_STRAIGHT)
		? SAR_DATA : (SAR_DATA ^ adc_seq_pkg::SIGN_FLIP);
	wire [15:0] result_word = {conv_chan_reg, coded};
	wire push = SAR_VALID && fifo_in_ready;

	// Register read selection; unmapped addresses read zero.
	wire [31:0] status_word = {21'h000000, !fifo_in_ready, mode_reg, ptr_reg, conv_chan_reg};
	wire [31:0] rd_mux = (ADDR == adc_seq_pkg::REG_CTRL) ? {20'h00000, ctrl_reg} :
		(ADDR == adc_seq_pkg::REG_MASK) ? {16'h0000, mask_reg} :
		(ADDR == adc_seq_pkg::REG_STATUS) ? status_word : 32'h00000000;

	// Result buffer between the converter and the serial output.
	result_fifo #(
		.WIDTH(adc_seq_pkg::WORD_W),
		.DEPTH(adc_seq_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(CLK),
		.rst_n(RST_N),
		.in_valid(SAR_VALID),
		.in_ready(fifo_in_ready),
		.in_data(result_word),
		.out_valid(fifo_out_valid),
		.out_ready(cs_fall),
		.out_data(fifo_out_data)
	);

	// Pin history for edge detection.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sclk_q_reg <= 1'b1;
			cs_n_q_reg <= 1'b1;
		end else begin
			sclk_q_reg <= SCLK;
			cs_n_q_reg <= CS_N;
		end
	end

	// Serial receive: count falling SCLK edges and catch the first twelve bits.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_cnt_reg <= '0;
			din_sh_reg <= '0;
			cap_reg <= '0;
			cap_valid_reg <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_reg <= '0;
			cap_valid_reg <= 1'b0;
		end else if (sclk_fall && (bit_cnt_reg != adc_seq_pkg::CNT_WORD)) begin
			bit_cnt_reg <= 5'(bit_cnt_reg + 1'b1);
			din_sh_reg <= {din_sh_reg[14:0], DIN};
			if (bit_cnt_reg == adc_seq_pkg::CNT_CTRL_LAST) begin
				cap_reg <= {din_sh_reg[10:0], DIN};
				cap_valid_reg <= 1'b1;
			end
		end
	end

	// Control word store; a serial word without the write bit leaves it unchanged, a bus write stores unless a serial control write lands in the same cycle.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_reg <= adc_seq_pkg::CTRL_RESET;
		end else if (wr_any) begin
			ctrl_reg <= wr_word;
		end
	end

	// Mask store, from the armed transfer or from the register port.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mask_reg <= adc_seq_pkg::MASK_RESET;
		end else if (mask_take) begin
			mask_reg <= din_sh_reg;
		end else if (bus_mask_wr) begin
			mask_reg <= WDATA[15:0];
		end
	end

	// Sequencer mode and pointer.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_reg <= adc_seq_pkg::SEQ_OFF;
			ptr_reg <= adc_seq_pkg::CHAN_ZERO;
			conv_chan_reg <= adc_seq_pkg::CHAN_ZERO;
		end else if (cs_fall) begin
			// Each sequenced conversion takes the pointer, then the pointer moves once.
			conv_chan_reg <= seq_idle ? last_chan : ptr_reg;
			if (mode_reg == adc_seq_pkg::SEQ_MASK) begin
				ptr_reg <= next_on(en_vec, ptr_reg);
			end else if (mode_reg == adc_seq_pkg::SEQ_CONSEC) begin
				ptr_reg <= (ptr_reg == last_chan) ? adc_seq_pkg::CHAN_ZERO
					: 4'(ptr_reg + 1'b1);
			end
		end else if (mask_take) begin
			// An empty mask leaves nothing to cycle.
			mode_reg <= (en_new == '0) ? adc_seq_pkg::SEQ_OFF : adc_seq_pkg::SEQ_MASK;
			ptr_reg <= next_on(en_new, adc_seq_pkg::CHAN_TOP);
		end else if (wr_any) begin
			case (wr_pat)
				2'h2: begin
					// Running sequence continues untouched.
					mode_reg <= mode_reg;
				end
				2'h1: begin
					mode_reg <= adc_seq_pkg::SEQ_ARM;
				end
				2'h3: begin
					mode_reg <= adc_seq_pkg::SEQ_CONSEC;
					ptr_reg <= adc_seq_pkg::CHAN_ZERO;
				end
				default: begin
					mode_reg <= adc_seq_pkg::SEQ_OFF;
				end
			endcase
		end else if (bus_mask_wr) begin
			mode_reg <= (WDATA[15:0] == '0) ? adc_seq_pkg::SEQ_OFF : adc_seq_pkg::SEQ_MASK;
			ptr_reg <= next_on(en_bus, adc_seq_pkg::CHAN_TOP);
		end
	end

	// Converter side: start pulse, channel select and ready hint.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			conv_start_reg <= 1'b0;
			mux_sel_reg <= adc_seq_pkg::CHAN_ZERO;
			sar_ready_reg <= 1'b0;
		end else begin
			conv_start_reg <= cs_fall;
			if (cs_fall) begin
				mux_sel_reg <= seq_idle ? last_chan : ptr_reg;
			end
			sar_ready_reg <= fifo_in_ready;
		end
	end

	// Serial output: a buffered word is loaded on CS fall and sent MSB first.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			out_sh_reg <= '0;
			dout_reg <= 1'b0;
			dout_oe_reg <= 1'b0;
		end else begin
			dout_oe_reg <= !CS_N;
			if (cs_fall) begin
				out_sh_reg <= fifo_out_valid ? fifo_out_data : '0;
				dout_reg <= fifo_out_valid && fifo_out_data[15];
			end else if (sclk_fall) begin
				out_sh_reg <= {out_sh_reg[14:0], 1'b0};
				dout_reg <= out_sh_reg[14];
			end
		end
	end

	// Register read data stands only in the cycle after the strobe.
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= RD ? rd_mux : 32'h00000000;
		end
	end

	assign DOUT = dout_reg;
	assign DOUT_OE = dout_oe_reg;
	assign MUX_SEL = mux_sel_reg;
	assign RANGE_SEL = ctrl_reg[adc_seq_pkg::BIT_RANGE];
	assign CONV_START = conv_start_reg;
	assign SAR_READY = sar_ready_reg;
	assign RDATA = rdata_reg;

	// Helper terms for the checks below.
	wire [15:0] below_mask = (16'h0001 << ptr_reg) - 16'h0001;
	wire lower_clear = ((en_vec & below_mask) == '0);
	wire [15:0] above_mask = ~((16'h0002 << ptr_reg) - 16'h0001);
	wire none_higher = ((en_vec & above_mask) == '0);

	AST_IDLE_CHAN: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_fall && seq_idle |=> MUX_SEL == $past(last_chan))
		else $error("Idle conversion did not use the address field.");
	AST_TAG: assert property (@(posedge CLK) disable iff (!RST_N)
		push |-> result_word[15:12] == MUX_SEL)
		else $error("Result word tag differs from converted channel.");
	AST_CODING: assert property (@(posedge CLK) disable iff (!RST_N)
		push && !ctrl_reg[adc_seq_pkg::BIT_CODING] |-> coded == (SAR_DATA ^ adc_seq_pkg::SIGN_FLIP))
		else $error("Two's complement coding not applied.");
	AST_RANGE: assert property (@(posedge CLK) disable iff (!RST_N)
		wr_any |=> RANGE_SEL == $past(wr_word[adc_seq_pkg::BIT_RANGE]))
		else $error("Range select did not follow control write.");
	AST_MASK_START: assert property (@(posedge CLK) disable iff (!RST_N)
		mask_take && (en_new != '0) |=> mode_reg == adc_seq_pkg::SEQ_MASK
			&& en_vec[ptr_reg] && lower_clear)
		else $error("Mask sequence did not start at lowest channel.");
	AST_MASK_STEP: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_fall && mode_reg == adc_seq_pkg::SEQ_MASK |=> en_vec[ptr_reg])
		else $error("Mask pointer moved to a disabled channel.");
	AST_MASK_WRAP: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_fall && mode_reg == adc_seq_pkg::SEQ_MASK && none_higher |=> lower_clear)
		else $error("Mask pointer did not wrap to lowest channel.");
	AST_MODE_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
		!wr_any && !mask_take && !bus_mask_wr |=> $stable(mode_reg))
		else $error("Mode changed without a write.");
	AST_STOP: assert property (@(posedge CLK) disable iff (!RST_N)
		!cs_fall && wr_any && wr_pat == 2'h0 |=> mode_reg == adc_seq_pkg::SEQ_OFF)
		else $error("Sequence not stopped by write.");
	AST_CONSEC: assert property (@(posedge CLK) disable iff (!RST_N)
		!cs_fall && wr_any && wr_pat == 2'h3 |=> mode_reg == adc_seq_pkg::SEQ_CONSEC
			&& ptr_reg == adc_seq_pkg::CHAN_ZERO)
		else $error("Consecutive mode did not start at channel zero.");
	AST_CONSEC_WRAP: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_fall && mode_reg == adc_seq_pkg::SEQ_CONSEC && ptr_reg == last_chan
			|=> ptr_reg == adc_seq_pkg::CHAN_ZERO ##1 ($stable(ptr_reg) || !$stable(CS_N)))
		else $error("Consecutive sequence did not restart at zero.");
	AST_MASK_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
		mask_take |=> mask_reg == $past(din_sh_reg))
		else $error("Mask not loaded from armed transfer.");
	AST_NO_WRITE: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_rise && cap_valid_reg && !cap_reg[adc_seq_pkg::BIT_WRITE] && !bus_ctrl_wr
			|=> $stable(ctrl_reg))
		else $error("Control changed without write bit.");
	AST_CONV_PULSE: assert property (@(posedge CLK) disable iff (!RST_N)
		cs_fall |=> CONV_START ##1 !CONV_START)
		else $error("Conversion start not one pulse per chip select fall.");
endmodule : adc_channel_sequencer

/* File: src/result_fifo.sv */
`timescale 1ns/1ns
// Result buffer with a registered output stage; holds DEPTH words plus the output word.
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
	localparam logic [AW:0] ZERO_COUNT = '0;

	logic [WIDTH-1:0] mem [DEPTH]; // Storage array.
	logic [AW-1:0] wr_ptr_reg; // Next slot to write.
	logic [AW-1:0] rd_ptr_reg; // Next slot to read.
	logic [AW:0] count_reg; // Words held in the array.
	logic [WIDTH-1:0] out_data_reg; // Output word register.
	logic out_valid_reg; // Output word is present.

	wire push = in_valid && in_ready;
	wire load = (count_reg != ZERO_COUNT) && (!out_valid_reg || out_ready);
	wire pop_out = out_valid_reg && out_ready;

	assign in_ready = (count_reg != FULL_COUNT);
	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;

	// The array itself needs no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers and the fill count.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= AW'(wr_ptr_reg + 1'b1);
			end
			if (load) begin
				rd_ptr_reg <= AW'(rd_ptr_reg + 1'b1);
			end
			count_reg <= (AW+1)'(count_reg + push - load);
		end
	end

	// The output stage refills whenever it is empty or being taken.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data_reg <= '0;
			out_valid_reg <= 1'b0;
		end else if (load) begin
			out_data_reg <= mem[rd_ptr_reg];
			out_valid_reg <= 1'b1;
		end else if (pop_out) begin
			out_valid_reg <= 1'b0;
		end
	end
endmodule : result_fifo

/* File: tb/host_serial_link.sv */
`timescale 1ns/1ns
// Behavioural host serial port.
// It drives chip select, the serial clock and the serial data, and collects the returned word.
module host_serial_link (
	input wire logic clk,
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout,
	output logic done,
	output logic [15:0] rx_word,
	output logic [4:0] rx_bits
);
	// Idle state: chip select high and the serial clock parked high between frames.
	initial begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b0;
		done = 1'b0;
		rx_word = 16'h0000;
		rx_bits = 5'h00;
	end
	// One frame of nb bits, most significant first, each clock phase hp cycles long.
	// A larger hp models a host that stalls between bits.
	task automatic xfer(input logic [15:0] tx, input logic [4:0] nb, input int hp);
		int i;
		repeat (3) @(posedge clk);
		cs_n <= 1'b0;
		din <= tx[15];
		rx_word <= 16'h0000;
		repeat (2) @(posedge clk);
		for (i = 0; i < nb; i++) begin
			repeat (hp) @(posedge clk);
			// The returned bit stands until the falling clock, so it is taken just before.
			rx_word <= {rx_word[14:0], dout};
			sclk <= 1'b0;
			repeat (hp) @(posedge clk);
			sclk <= 1'b1;
			din <= (i < 15) ? tx[14 - i] : ~din;
		end
		repeat (hp) @(posedge clk);
		cs_n <= 1'b1;
		// The released data line inverts its level, so after a full 16-bit frame it shows the last bit again.
		din <= ~din;
		rx_bits <= nb;
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
	endtask : xfer
endmodule : host_serial_link

/* File: tb/testbench.sv */
`timescale 1ns/1ns
// Self-checking bench for the channel sequencer.
module testbench;
	logic CLK, RST_N, SCLK, CS_N, DIN, DOUT, DOUT_OE, RANGE_SEL, CONV_START;
	logic SAR_VALID, SAR_READY, WR, RD, done, rd_d, chk_ch, coding;
	logic [3:0] MUX_SEL, exp_ch, last;
	logic [11:0] SAR_DATA;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA;
	logic [15:0] rx_word, wexp, seed;
	logic [4:0] rx_bits;
	logic [1:0] rc;
	logic [63:0] rdn;
	logic [15:0] exp_q[$]; // Expected result words in buffer order.
	logic [63:0] rd_q[$]; // Expected read data above a compare mask.
	int avail, fails, tests_run, cycles, i, fill;

	// Clock of 100 MHz.
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end

	adc_channel_sequencer adc_channel_sequencer_inst (.CLK(CLK), .RST_N(RST_N), .SCLK(SCLK),
		.CS_N(CS_N), .DIN(DIN), .DOUT(DOUT), .DOUT_OE(DOUT_OE), .MUX_SEL(MUX_SEL),
		.RANGE_SEL(RANGE_SEL), .CONV_START(CONV_START), .SAR_VALID(SAR_VALID),
		.SAR_DATA(SAR_DATA), .SAR_READY(SAR_READY), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
		.RD(RD), .RDATA(RDATA));
	host_serial_link host_serial_link_inst (.clk(CLK), .sclk(SCLK), .cs_n(CS_N), .din(DIN),
		.dout(DOUT), .done(done), .rx_word(rx_word), .rx_bits(rx_bits));

	// Counts a comparison and reports a mismatch.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Prints the verdict and ends the run.
	task automatic close_out();
		if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	// Pseudo-random source.
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	// Serial control word with the write bit set, padded to a full frame.
	function automatic logic [15:0] cw(input logic au, input logic ms, input logic [3:0] ad,
		input logic rg, input logic cd);
		return {1'b1, au, ad, 2'b00, ms, 1'b0, rg, cd, 4'h0};
	endfunction : cw

	// Result word: channel tag above the code in the selected coding.
	function automatic logic [15:0] word(input logic [3:0] ch, input logic [11:0] raw);
		return {ch, (coding == adc_seq_pkg::CODING_STRAIGHT) ? raw : raw ^ adc_seq_pkg::SIGN_FLIP};
	endfunction : word

	// Register port write, one strobe cycle.
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : bus_wr

	// Register port read; the expectation is noted for the monitor.
	task automatic bus_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		rd_q.push_back({e, m});
		@(posedge CLK);
		RD <= 0;
	endtask : bus_rd

	// Full serial frame; ch is the channel this frame should convert, chk enables the answer.
	task automatic go(input logic [15:0] w, input logic [3:0] ch, input logic chk, input int hp);
		exp_ch = ch;
		chk_ch = chk;
		host_serial_link_inst.xfer(w, 5'h10, hp);
	endtask : go

	// Fills the buffer to the brim plus one result that must be dropped.
	// The converter model sends the words; the buffer holds 32 plus its output word.
	task automatic burst();
		fill = 34 - exp_q.size();
		wait (fill == 0);
		@(posedge CLK);
	endtask : burst

	// Converter model: answers each checked conversion start, or fills the buffer when asked.
	initial begin
		seed = 16'h0049;
		SAR_VALID = 1'b0;
		SAR_DATA = 12'h000;
		forever begin
			@(posedge CLK);
			if ((CONV_START === 1'b1) && (fill == 0)) begin
				avail = exp_q.size();
				if (chk_ch === 1'b1) begin
					check("mux_sel", MUX_SEL, exp_ch);
					check("dout_oe", DOUT_OE, 1'b1);
				end
			end
			seed = lfsr(seed);
			SAR_DATA <= seed[11:0];
			SAR_VALID <= (fill > 0) || ((CONV_START === 1'b1) && (chk_ch === 1'b1));
			// The last word of a fill meets a full buffer and is dropped.
			if ((fill > 1) || ((fill == 0) && (CONV_START === 1'b1) && (chk_ch === 1'b1))) begin
				exp_q.push_back(word(exp_ch, seed[11:0]));
			end
			if (fill > 0) fill--;
		end
	end

	// Monitor: compares read data and returned serial words with the oldest notes.
	always @(posedge CLK) begin
		rd_d <= RD;
		if (rd_d === 1'b1) begin
			rdn = rd_q.pop_front();
			check("rdata", RDATA & rdn[31:0], rdn[63:32]);
		end
		if (done === 1'b1) begin
			if (avail > 0) wexp = exp_q.pop_front();
			else wexp = 16'h0000;
			if (rx_bits == 5'h10) check("dout_word", rx_word, wexp);
		end
	end

	// Watchdog: a hang counts as a mismatch.
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 60000) begin
			fails++;
			close_out();
		end
	end

	// Main sequence.
	initial begin
		{fails, tests_run} = '0;
		{RST_N, WR, RD, coding} = '0;
		{ADDR, WDATA, exp_ch, last} = '0;
		chk_ch = 1'b1;
		repeat (10) @(posedge CLK);
		RST_N <= 1'b1;
		bus_rd(adc_seq_pkg::REG_CTRL, 32'h0, 32'hFFFFFFFF);
		bus_rd(adc_seq_pkg::REG_MASK, 32'h0, 32'hFFFFFFFF);
		check("range_sel", RANGE_SEL, 0);
		check("dout_oe", DOUT_OE, 0);
		// Every channel addressed directly, with random span and coding.
		for (i = 0; i < 16; i++) begin
			rc = seed[1:0];
			go(cw(1'b0, 1'b0, i[3:0], rc[0], rc[1]), last, 1, 2);
			coding = rc[1];
			repeat (3) @(posedge CLK);
			check("range_sel", RANGE_SEL, rc[0]);
			last = i[3:0];
		end
		// Write bit low, then a short frame: the control word must not change.
		go({1'b0, 15'h7FFF}, last, 1, 2);
		chk_ch = 1'b0;
		host_serial_link_inst.xfer(cw(1'b0, 1'b0, 4'h9, 1'b0, coding), 5'h08, 2);
		go(16'h0000, last, 1, 2);
		// Consecutive channels up to 3 with wrap; data line held low meanwhile.
		go(cw(1'b1, 1'b1, 4'h3, 1'b0, coding), last, 1, 2);
		for (i = 0; i < 6; i++) go(16'h0000, 4'(i % 4), 1, 2);
		go(cw(1'b1, 1'b0, 4'h3, 1'b0, ~coding), 4'h2, 1, 2);
		coding = ~coding;
		go(16'h0000, 4'h3, 1, 2);
		go(cw(1'b0, 1'b0, 4'h5, 1'b0, coding), 4'h0, 1, 2);
		// Arm, load channels 2, 7 and 15, then run the masked sequence.
		go(cw(1'b0, 1'b1, 4'h5, 1'b0, coding), 4'h5, 1, 2);
		go(16'h2101, 4'h0, 0, 2);
		for (i = 0; i < 5; i++) begin
			exp_ch = (i % 3 == 0) ? 4'h2 : ((i % 3 == 1) ? 4'h7 : 4'hF);
			go(16'h0000, exp_ch, 1, 2);
		end
		go(cw(1'b0, 1'b0, 4'h4, 1'b0, coding), 4'hF, 1, 2);
		go(16'h0000, 4'h4, 1, 2);
		// Mask over the register port: channels 5 and 11.
		bus_wr(adc_seq_pkg::REG_MASK, 32'h00000410);
		bus_rd(adc_seq_pkg::REG_MASK, 32'h00000410, 32'hFFFFFFFF);
		go(16'h0000, 4'h5, 1, 3);
		go(16'h0000, 4'hB, 1, 3);
		go(16'h0000, 4'h5, 1, 3);
		bus_wr(adc_seq_pkg::REG_MASK, 32'h0);
		go(16'h0000, 4'h4, 1, 2);
		// Control over the register port: channel 7, narrow span, straight binary.
		bus_wr(adc_seq_pkg::REG_CTRL, 32'h000001C3);
		bus_rd(adc_seq_pkg::REG_CTRL, 32'h000001C3, 32'h000007CB);
		check("range_sel", RANGE_SEL, 1);
		coding = 1'b1;
		go(16'h0000, 4'h7, 1, 2);
		bus_wr(8'h0C, {seed, seed});
		bus_rd(8'h0C, 32'h0, 32'hFFFFFFFF);
		// Fill the buffer until it refuses, then drain it with a slow host.
		burst();
		@(posedge CLK);
		check("sar_ready", SAR_READY, 0);
		bus_rd(adc_seq_pkg::REG_STATUS, 32'h00000400, 32'h00000400);
		for (i = 0; i < 34; i++) go(16'h0000, 4'h7, 0, 3);
		bus_rd(adc_seq_pkg::REG_STATUS, 32'h0, 32'h00000400);
		check("sar_ready", SAR_READY, 1);
		repeat (5) @(posedge CLK);
		close_out();
	end
endmodule : testbench
